// file: rtl/arm_regs.vh
// register map, field positions, reset values and timing for arm_ctrl
// assumes a 32-bit avalon-mm slave with byte addresses on word boundaries
`ifndef ARM_REGS_VH
`define ARM_REGS_VH
// register byte offsets
`define ARM_OFF_CTRL    8'h00
`define ARM_OFF_CHSEL   8'h04
`define ARM_OFF_STATUS  8'h08
`define ARM_OFF_ISTAT   8'h0c
`define ARM_OFF_IMASK   8'h10
// windows: results 0x20..0x3c, limits 0x40..0x5c, dac code 0x60..0x6c, dac cfg 0x70..0x7c
`define ARM_WIN_RES     3'h1
`define ARM_WIN_LIM     3'h2
`define ARM_WIN_DCODE   4'h6
`define ARM_WIN_DCFG    4'h7
// control fields
`define ARM_CTRL_START  0
`define ARM_CTRL_CONT   1
`define ARM_CTRL_AVG    2
// limit fields: [11:0] threshold, bit 16 set = upper threshold
`define ARM_LIM_UPPER   16
// dac cfg fields
`define ARM_DCFG_LO_LSB 0
`define ARM_DCFG_HI_LSB 8
`define ARM_DCFG_RNG_LSB 16
`define ARM_DCFG_EN     24
// interrupt status: bit 0 loop done, bits 15:8 channel warnings
`define ARM_IRQ_DONE    0
`define ARM_IRQ_WARN    8
// reset values
`define ARM_LIM_RST     12'hfff
`define ARM_LIM_UP_RST  1'b1
`define ARM_DCODE_RST   8'h7f
`define ARM_DLO_RST     8'h00
`define ARM_DHI_RST     8'hff
`define ARM_CHSEL_RST   8'h00
// timing
`define ARM_CLK_NS      4
`define ARM_CONV_NS     500000
`define ARM_TRACK_NS    10000
`define ARM_AVG_LAST    4'hf
`endif

// file: rtl/arm_ctrl.v
// adc round-robin sequencer, limit warnings and margin dac control
// assumes one 250 mhz clock, an external adc that settles within a conversion
// window, avalon-mm register access and a sequencing engine start input
//
// Chosen here: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`include "arm_regs.vh"

module arm_ctrl #(
    // conversion window in cycles, shortened in simulation
    parameter CONV_CYC = `ARM_CONV_NS / `ARM_CLK_NS
) (
    input  wire        core_clk,
    input  wire        reset_n,
    input  wire [7:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    output wire [31:0] avs_readdata,
    output wire        avs_waitrequest,
    input  wire [11:0] adc_data,
    output wire [2:0]  adc_mux_sel,
    output wire        adc_convert,
    input  wire        sequencing_engine_start,
    output wire [7:0]  sequencing_engine_warn,
    output wire        irq,
    output wire [31:0] dac_code_out,
    output wire [7:0]  dac_range_out,
    output wire [3:0]  dac_track_out,
    output wire [3:0]  dac_drive_out
);

    // sequencer states
    localparam S_IDLE = 2'd0;
    localparam S_SCAN = 2'd1;
    localparam S_CONV = 2'd2;
    localparam S_END  = 2'd3;
    // buffer tracking time, rounded up
    localparam TRACK_CYC = (`ARM_TRACK_NS + `ARM_CLK_NS - 1) / `ARM_CLK_NS;
    localparam [31:0] CONV_LAST_W  = CONV_CYC - 1;
    localparam [31:0] TRACK_LAST_W = TRACK_CYC - 1;
    localparam [16:0] CONV_LAST    = CONV_LAST_W[16:0];
    localparam [11:0] TRACK_LAST   = TRACK_LAST_W[11:0];

    integer k;    // sequencer loop index
    integer j;    // register loop index

    // reset synchroniser
    reg        rst_meta_reg;
    reg        rst_n_reg;
    wire       rst_n = rst_n_reg;

    // bus slave
    reg        ack_reg;       // answer phase of an access
    reg [31:0] rdata_reg;     // registered read data
    reg [31:0] rdata_next;    // read mux
    wire       wr_hit = avs_write & ack_reg;

    // control and configuration
    reg        cont_reg;      // continuous loop mode
    reg        avg_reg;       // sixteen-loop averaging
    reg [7:0]  chsel_reg;     // selected channels
    reg [15:0] istat_reg;     // sticky events
    reg [15:0] imask_reg;     // interrupt enables
    reg [11:0] lim_mem [0:7]; // per-channel threshold
    reg [7:0]  lim_up_reg;    // threshold direction
    reg [7:0]  dcode_mem [0:3];
    reg [7:0]  dlo_mem [0:3];
    reg [7:0]  dhi_mem [0:3];
    reg [1:0]  drng_mem [0:3];
    reg [3:0]  den_reg;

    // sequencer
    reg [1:0]  state_reg;
    reg [2:0]  ch_reg;        // channel under scan
    reg [3:0]  pass_reg;      // averaging loop count
    reg [16:0] cnt_reg;       // conversion window count
    reg [15:0] acc_mem [0:7]; // per-channel sum
    reg [11:0] res_mem [0:7]; // readable results
    reg [7:0]  warn_reg;      // live warnings
    reg [7:0]  warn_evt_reg;  // warning pulse at each loop end
    reg        done_reg;      // loop complete pulse
    reg [2:0]  mux_reg;
    reg        conv_reg;
    reg        eng_start_d_reg; // engine start, one cycle late

    // start requests from host write or engine edge
    // host or engine start
    wire host_start = wr_hit && avs_address == `ARM_OFF_CTRL && avs_writedata[`ARM_CTRL_START];
    wire eng_start  = sequencing_engine_start & ~eng_start_d_reg;
    wire start_req  = host_start | eng_start;

    // averaged or single value from a sum
    function [11:0] arm_val;
        input [15:0] sum;
        input        avg;
        begin
            arm_val = avg ? sum[15:4] : sum[11:0];
        end
    endfunction

    // limit comparison for one channel
    function arm_cross;
        input [11:0] val;
        input [11:0] lim;
        input        up;
        begin
            arm_cross = up ? (val > lim) : (val < lim);
        end
    endfunction

    // release reset through two flops
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_reg <= 1'b0;
            rst_n_reg    <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n_reg    <= rst_meta_reg;
        end
    end

    // one wait cycle, then answer
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
    assign avs_readdata    = rdata_reg;

    // read decode
    always @* begin
        rdata_next = 32'h0000_0000;
        case (avs_address[7:5])
            3'h0: begin
                case (avs_address)
                    `ARM_OFF_CTRL:   rdata_next = {29'h0000_0000, avg_reg, cont_reg, 1'b0};
                    `ARM_OFF_CHSEL:  rdata_next = {24'h00_0000, chsel_reg};
                    `ARM_OFF_STATUS: rdata_next = {13'h0000, ch_reg, warn_reg, 3'h0, pass_reg,
                                                   state_reg != S_IDLE};
                    `ARM_OFF_ISTAT:  rdata_next = {16'h0000, istat_reg};
                    `ARM_OFF_IMASK:  rdata_next = {16'h0000, imask_reg};
                    default:         rdata_next = 32'h0000_0000;
                endcase
            end
            `ARM_WIN_RES: rdata_next = {20'h0_0000, res_mem[avs_address[4:2]]};
            `ARM_WIN_LIM: rdata_next = {15'h0000, lim_up_reg[avs_address[4:2]], 4'h0,
                                        lim_mem[avs_address[4:2]]};
            3'h3: begin
                if (avs_address[4] == 1'b0)
                    rdata_next = {24'h00_0000, dcode_mem[avs_address[3:2]]};
                else
                    rdata_next = {7'h00, den_reg[avs_address[3:2]], 6'h00, drng_mem[avs_address[3:2]],
                                  dhi_mem[avs_address[3:2]], dlo_mem[avs_address[3:2]]};
            end
            default: rdata_next = 32'h0000_0000;
        endcase
    end

    // bus handshake and read data capture
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_reg   <= 1'b0;
            rdata_reg <= 32'h0000_0000;
        end else begin
            ack_reg <= (avs_read | avs_write) & ~ack_reg;
            if (avs_read & ~ack_reg)
                rdata_reg <= rdata_next;
        end
    end

    // register writes and sticky interrupt status
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cont_reg   <= 1'b0;
            avg_reg    <= 1'b0;
            chsel_reg  <= `ARM_CHSEL_RST;
            istat_reg  <= 16'h0000;
            imask_reg  <= 16'h0000;
            lim_up_reg <= {8{`ARM_LIM_UP_RST}};
            den_reg    <= 4'h0;
            for (j = 0; j < 8; j = j + 1)
                lim_mem[j] <= `ARM_LIM_RST;
            for (j = 0; j < 4; j = j + 1) begin
                dcode_mem[j] <= `ARM_DCODE_RST;
                dlo_mem[j]   <= `ARM_DLO_RST;
                dhi_mem[j]   <= `ARM_DHI_RST;
                drng_mem[j]  <= 2'h0;
            end
        end else begin
            if (wr_hit) begin
                case (avs_address[7:4])
                    4'h0, 4'h1: begin
                        if (avs_address == `ARM_OFF_CTRL) begin
                            cont_reg <= avs_writedata[`ARM_CTRL_CONT];
                            avg_reg  <= avs_writedata[`ARM_CTRL_AVG];
                        end
                        if (avs_address == `ARM_OFF_CHSEL)
                            chsel_reg <= avs_writedata[7:0];
                        if (avs_address == `ARM_OFF_IMASK)
                            imask_reg <= avs_writedata[15:0];
                    end
                    4'h4, 4'h5: begin
                        lim_mem[avs_address[4:2]]    <= avs_writedata[11:0];
                        lim_up_reg[avs_address[4:2]] <= avs_writedata[`ARM_LIM_UPPER];
                    end
                    `ARM_WIN_DCODE: dcode_mem[avs_address[3:2]] <= avs_writedata[7:0];
                    `ARM_WIN_DCFG: begin
                        dlo_mem[avs_address[3:2]]  <= avs_writedata[`ARM_DCFG_LO_LSB +: 8];
                        dhi_mem[avs_address[3:2]]  <= avs_writedata[`ARM_DCFG_HI_LSB +: 8];
                        drng_mem[avs_address[3:2]] <= avs_writedata[`ARM_DCFG_RNG_LSB +: 2];
                        den_reg[avs_address[3:2]]  <= avs_writedata[`ARM_DCFG_EN];
                    end
                    default: ;
                endcase
            end
            // write one clears, a new event wins
            // warning into status
            istat_reg <= (istat_reg & ~((wr_hit && avs_address == `ARM_OFF_ISTAT) ?
                          avs_writedata[15:0] : 16'h0000))
                         | {warn_evt_reg, 7'h00, done_reg};
        end
    end

    assign irq = |(istat_reg & imask_reg);

    // round-robin sequencer
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg      <= S_IDLE;
            ch_reg         <= 3'h0;
            pass_reg       <= 4'h0;
            cnt_reg        <= 17'h0_0000;
            warn_reg       <= 8'h00;
            warn_evt_reg   <= 8'h00;
            done_reg       <= 1'b0;
            mux_reg        <= 3'h0;
            conv_reg       <= 1'b0;
            eng_start_d_reg <= 1'b0;
            for (k = 0; k < 8; k = k + 1) begin
                acc_mem[k] <= 16'h0000;
                res_mem[k] <= 12'h000;
            end
        end else begin
            eng_start_d_reg <= sequencing_engine_start;
            conv_reg       <= 1'b0;
            done_reg       <= 1'b0;
            warn_evt_reg   <= 8'h00;
            case (state_reg)
                S_IDLE: begin
                    if (start_req) begin
                        ch_reg    <= 3'h0;
                        pass_reg  <= 4'h0;
                        state_reg <= S_SCAN;
                    end
                end
                S_SCAN: begin
                    if (chsel_reg[ch_reg]) begin
                        mux_reg   <= ch_reg;
                        conv_reg  <= 1'b1;
                        cnt_reg   <= 17'h0_0000;
                        state_reg <= S_CONV;
                    end else if (ch_reg == 3'h7) begin
                        state_reg <= S_END;
                    end else begin
                        ch_reg <= ch_reg + 3'h1;
                    end
                end
                S_CONV: begin
                    if (cnt_reg == CONV_LAST) begin
                        acc_mem[ch_reg] <= acc_mem[ch_reg] + {4'h0, adc_data};
                        if (ch_reg == 3'h7)
                            state_reg <= S_END;
                        else begin
                            ch_reg    <= ch_reg + 3'h1;
                            state_reg <= S_SCAN;
                        end
                    end else begin
                        cnt_reg <= cnt_reg + 17'h0_0001;
                    end
                end
                S_END: begin
                    ch_reg <= 3'h0;
                    if (avg_reg && pass_reg != `ARM_AVG_LAST) begin
                        pass_reg  <= pass_reg + 4'h1;
                        state_reg <= S_SCAN;
                    end else begin
                        pass_reg <= 4'h0;
                        done_reg <= 1'b1;
                        for (k = 0; k < 8; k = k + 1) begin
                            acc_mem[k] <= 16'h0000;
                            if (chsel_reg[k]) begin
                                res_mem[k] <= arm_val(acc_mem[k], avg_reg);
                                warn_reg[k] <= arm_cross(arm_val(acc_mem[k], avg_reg),
                                                         lim_mem[k], lim_up_reg[k]);
                                warn_evt_reg[k] <= arm_cross(arm_val(acc_mem[k], avg_reg),
                                                             lim_mem[k], lim_up_reg[k]);
                            end else begin
                                warn_reg[k] <= 1'b0;
                            end
                        end
                        state_reg <= cont_reg ? S_SCAN : S_IDLE;
                    end
                end
                default: state_reg <= S_IDLE;
            endcase
        end
    end

    assign adc_mux_sel = mux_reg;
    assign adc_convert = conv_reg;
    assign sequencing_engine_warn = warn_reg;

    // margin dac channels
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_dac
            reg [7:0]  code_reg;   // applied code
            reg [1:0]  rng_reg;    // applied range
            reg        track_reg;  // buffer follows pin
            reg        drive_reg;  // buffer drives dac
            reg [11:0] tcnt_reg;   // tracking time
            wire bad = dlo_mem[g] > dhi_mem[g];
            always @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    code_reg  <= `ARM_DCODE_RST;
                    rng_reg   <= 2'h0;
                    track_reg <= 1'b0;
                    drive_reg <= 1'b0;
                    tcnt_reg  <= 12'h000;
                end else begin
                    if (dcode_mem[g] < dlo_mem[g])
                        code_reg <= dlo_mem[g];
                    else if (dcode_mem[g] > dhi_mem[g])
                        code_reg <= dhi_mem[g];
                    else
                        code_reg <= dcode_mem[g];
                    rng_reg <= drng_mem[g];
                    if (!den_reg[g] || bad) begin
                        track_reg <= 1'b0;
                        drive_reg <= 1'b0;
                        tcnt_reg  <= 12'h000;
                    end else if (!track_reg && !drive_reg) begin
                        track_reg <= 1'b1;
                        tcnt_reg  <= 12'h000;
                    end else if (track_reg) begin
                        if (tcnt_reg == TRACK_LAST) begin
                            track_reg <= 1'b0;
                            drive_reg <= 1'b1;
                        end else begin
                            tcnt_reg <= tcnt_reg + 12'h001;
                        end
                    end
                end
            end
            // code clamped to the dac cfg low and high limits, passed to the dac
            assign dac_code_out[g*8 +: 8]  = code_reg;
            assign dac_range_out[g*2 +: 2] = rng_reg;
            assign dac_track_out[g]        = track_reg;
            assign dac_drive_out[g]        = drive_reg;
        end
    endgenerate

endmodule // arm_ctrl

// file: testbench/arm_ctrl_checker.sv
// port-level assertions for arm_ctrl
// assumes one core_clk domain and the async active-low reset_n
`timescale 1ns/100ps
module arm_ctrl_checker #(
    parameter CONV_CYC = 8
) (
    input wire        core_clk,
    input wire        reset_n,
    input wire        avs_read,
    input wire        avs_write,
    input wire        avs_waitrequest,
    input wire [31:0] avs_readdata,
    input wire        adc_convert,
    input wire [2:0]  adc_mux_sel,
    input wire        irq,
    input wire [31:0] dac_code_out,
    input wire [7:0]  dac_range_out,
    input wire [3:0]  dac_track_out,
    input wire [3:0]  dac_drive_out
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    // a write answered by the slave this cycle
    wire wr_ack = avs_write && !avs_waitrequest;
    AST_ONE_WAIT: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus access held off for more than one cycle");
    AST_MUX_HOLD: assert property (adc_convert |=> $stable(adc_mux_sel) [*7])
        else $error("mux moved inside a conversion window");
    AST_CONV_GAP: assert property (adc_convert |=> !adc_convert [*8])
        else $error("conversions closer than one window");
    AST_NOT_BOTH: assert property ((dac_track_out & dac_drive_out) == 4'h0)
        else $error("buffer tracking and driving at once");
    AST_TRACK_FIRST: assert property ((dac_drive_out & ~$past(dac_drive_out) & ~$past(dac_track_out)) == 4'h0)
        else $error("buffer drove without tracking first");
    AST_READ_HOLD: assert property ($changed(avs_readdata) |-> $past(avs_read && avs_waitrequest))
        else $error("read data changed without a read");
    AST_CODE_CAUSE: assert property ($changed(dac_code_out) |-> $past(wr_ack) || $past(wr_ack, 2))
        else $error("applied dac code changed without a write");
    AST_RANGE_CAUSE: assert property ($changed(dac_range_out) |-> $past(wr_ack) || $past(wr_ack, 2))
        else $error("dac range changed without a write");
    COV_CONV: cover property (adc_convert);
    COV_DRIVE: cover property ($rose(dac_drive_out[1]));
    COV_IRQ: cover property ($rose(irq));
endmodule // arm_ctrl_checker
// attach the checker to every arm_ctrl instance
bind arm_ctrl arm_ctrl_checker #(.CONV_CYC(CONV_CYC)) u_arm_chk (
    .core_clk(core_clk), .reset_n(reset_n), .avs_read(avs_read), .avs_write(avs_write),
    .avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata), .adc_convert(adc_convert),
    .adc_mux_sel(adc_mux_sel), .irq(irq), .dac_code_out(dac_code_out), .dac_range_out(dac_range_out),
    .dac_track_out(dac_track_out), .dac_drive_out(dac_drive_out));

// file: testbench/arm_adc_model.sv
// converter model: code {channel, 0, per-channel count}
// assumes a one-cycle start pulse and a window of CONV_CYC cycles
`timescale 1ns/100ps
module arm_adc_model #(
    parameter CONV_CYC = 8
) (
    input  wire        core_clk,
    input  wire        reset_n,
    input  wire        adc_convert,
    input  wire [2:0]  adc_mux_sel,
    output reg  [11:0] adc_data
);
    reg [3:0]  cnt_reg [0:7];  // conversions seen per channel
    reg [15:0] win_reg;        // cycles left in the window
    integer    i;
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            for (i = 0; i < 8; i = i + 1) cnt_reg[i] <= 4'h0;
            win_reg <= 16'h0000;
            adc_data <= 12'h000;
        end else if (adc_convert) begin
            // code held for the whole window
            adc_data <= {adc_mux_sel, 5'h00, cnt_reg[adc_mux_sel]};
            cnt_reg[adc_mux_sel] <= cnt_reg[adc_mux_sel] + 4'h1;
            win_reg <= 16'(CONV_CYC);
        end else if (win_reg > 16'h0001) begin
            win_reg <= win_reg - 16'h0001;
        end else begin
            // outside a window the code is not valid: toggle it
            win_reg <= 16'h0000;
            adc_data <= ~adc_data;
        end
    end
endmodule // arm_adc_model

// file: testbench/test_adc_round_robin_and_margin_dac_control.sv
// self-checking bench for arm_ctrl: sequencer, warnings, interrupt, margin dacs
// assumes arm_adc_model on the converter side; the bench is host and engine
`timescale 1ns/100ps
`define CHK(nm, e, s) begin comparisons = comparisons + 1; if ((s) !== (e)) begin \
    err_total = err_total + 1; $display("wrong value %s exp %h got %h", nm, e, s); end end
module test_adc_round_robin_and_margin_dac_control;
    reg         core_clk;          // 250 mhz clock
    reg         reset_n;           // async reset, active low
    reg  [7:0]  avs_address;       // host bus signals
    reg         avs_read;
    reg         avs_write;
    reg  [31:0] avs_writedata;
    wire [31:0] avs_readdata;
    wire        avs_waitrequest;
    wire [11:0] adc_data;          // converter side
    wire [2:0]  adc_mux_sel;
    wire        adc_convert;
    reg         sequencing_engine_start; // engine start level
    wire [7:0]  sequencing_engine_warn;
    wire        irq;
    wire [31:0] dac_code_out;      // margin dac side
    wire [7:0]  dac_range_out;
    wire [3:0]  dac_track_out;
    wire [3:0]  dac_drive_out;
    integer     err_total = 0;     // mismatches
    integer     comparisons = 0;   // checks made
    integer     conv_n = 0;        // conversion pulses seen
    integer     c0, n, i;
    reg  [31:0] rd;                // last read word
    arm_ctrl #(.CONV_CYC(8)) DUT (
        .core_clk(core_clk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .adc_data(adc_data), .adc_mux_sel(adc_mux_sel),
        .adc_convert(adc_convert), .sequencing_engine_start(sequencing_engine_start),
        .sequencing_engine_warn(sequencing_engine_warn), .irq(irq),
        .dac_code_out(dac_code_out), .dac_range_out(dac_range_out), .dac_track_out(dac_track_out),
        .dac_drive_out(dac_drive_out));
    arm_adc_model #(.CONV_CYC(8)) u_adc (
        .core_clk(core_clk), .reset_n(reset_n), .adc_convert(adc_convert),
        .adc_mux_sel(adc_mux_sel), .adc_data(adc_data));
    // clock generator
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    // count conversion starts
    always @(posedge core_clk) begin
        if (adc_convert) conv_n <= conv_n + 1;
    end
    // one bus access: held until waitrequest is seen low, then released
    task bus(input logic is_wr, input logic [7:0] a, input logic [31:0] d);
        integer k;
        begin
            @(posedge core_clk);
            avs_address <= a;
            avs_writedata <= d;
            avs_write <= is_wr;
            avs_read <= !is_wr;
            k = 0;
            @(posedge core_clk);
            while (avs_waitrequest !== 1'b0 && k < 20) begin
                @(posedge core_clk);
                k = k + 1;
            end
            if (k == 20) err_total = err_total + 1;
            rd = avs_readdata;
            avs_write <= 1'b0;
            avs_read <= 1'b0;
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d); bus(1'b1, a, d); endtask
    task rdr(input logic [7:0] a); bus(1'b0, a, 32'h0); endtask
    task settle; begin @(negedge core_clk); @(negedge core_clk); end endtask
    // poll loop done, then clear it
    task wait_done;
        begin
            n = 0;
            rd = 0;
            while (rd[0] !== 1'b1 && n < 2000) begin
                rdr(8'h0c);
                n = n + 1;
            end
            `CHK("loop done", 1'b1, rd[0])
            wr(8'h0c, 32'h0000_0001);
        end
    endtask
    // reset values and an unmapped read
    task t_reset;
        begin
            `CHK("dac code", 32'h7f7f_7f7f, dac_code_out)
            `CHK("buffers", 4'h0, dac_drive_out | dac_track_out)
            rdr(8'h40);
            `CHK("limit 0", 32'h0001_0fff, rd)
            rdr(8'h70);
            `CHK("dac cfg 0", 32'h0000_ff00, rd)
            rdr(8'hfc);
            `CHK("unmapped", 32'h0000_0000, rd)
        end
    endtask
    // single pass over a sparse channel set
    task t_single;
        begin
            wr(8'h04, 32'h0000_00a5);
            c0 = conv_n;
            wr(8'h00, 32'h0000_0001);
            wait_done;
            `CHK("conversions", 4, conv_n - c0)
            for (i = 0; i < 8; i = i + 1) begin
                rdr(8'h20 + 8'(4 * i));
                `CHK("result", ((8'ha5 >> i) & 1) ? i << 9 : 0, rd & 32'hffff_fff0)
            end
        end
    endtask
    // engine start, limits, warnings and interrupt
    task t_warn;
        begin
            wr(8'h48, 32'h0001_03ff);
            wr(8'h54, 32'h0000_09ff);
            wr(8'h5c, 32'h0000_0fff);
            wr(8'h10, 32'h0000_0400);
            sequencing_engine_start <= 1'b1;
            wait_done;
            sequencing_engine_start <= 1'b0;
            `CHK("engine warn", 8'h84, sequencing_engine_warn)
            rdr(8'h08);
            `CHK("status warn", 8'h84, rd[15:8])
            settle;
            `CHK("irq raised", 1'b1, irq)
            wr(8'h10, 32'h0000_0000);
            settle;
            `CHK("irq masked", 1'b0, irq)
            wr(8'h10, 32'h0000_0400);
            wr(8'h0c, 32'h0000_ff00);
            settle;
            `CHK("irq cleared", 1'b0, irq)
        end
    endtask
    // averaging over sixteen loops
    task t_avg;
        begin
            wr(8'h04, 32'h0000_000c);
            c0 = conv_n;
            wr(8'h00, 32'h0000_0005);
            wait_done;
            `CHK("avg conversions", 32, conv_n - c0)
            rdr(8'h28);
            `CHK("avg ch2", 32'h0000_0407, rd)
            rdr(8'h2c);
            `CHK("avg ch3", 32'h0000_0607, rd)
        end
    endtask
    // empty set, continuous mode and its stop
    task t_cont;
        begin
            wr(8'h04, 32'h0000_0000);
            c0 = conv_n;
            wr(8'h00, 32'h0000_0001);
            wait_done;
            `CHK("empty loop", 0, conv_n - c0)
            wr(8'h04, 32'h0000_0001);
            c0 = conv_n;
            wr(8'h00, 32'h0000_0003);
            wait_done;
            wait_done;
            wr(8'h00, 32'h0000_0000);
            rd = 1;
            n = 0;
            while (rd[0] !== 1'b0 && n < 200) begin
                rdr(8'h08);
                n = n + 1;
            end
            `CHK("stopped", 1'b0, rd[0])
            `CHK("repeated", 1'b1, conv_n - c0 >= 2)
            c0 = conv_n;
            repeat (60) @(posedge core_clk);
            `CHK("no rerun", 0, conv_n - c0)
        end
    endtask
    // ranges, clamping, glitch-free enable, hi-z
    task t_dac;
        begin
            for (i = 0; i < 4; i = i + 1) wr(8'h70 + 8'(4 * i), (i << 16) | 32'h0000_ff00);
            settle;
            `CHK("ranges", 8'he4, dac_range_out)
            wr(8'h64, 32'h0000_0020);
            wr(8'h74, 32'h0101_c030);
            settle;
            `CHK("clamp low", 8'h30, dac_code_out[15:8])
            `CHK("tracking", 2'b01, {dac_drive_out[1], dac_track_out[1]})
            n = 0;
            while (dac_drive_out[1] !== 1'b1 && n < 3000) begin
                @(negedge core_clk);
                n = n + 1;
            end
            `CHK("driving", 2'b10, {dac_drive_out[1], dac_track_out[1]})
            wr(8'h64, 32'h0000_00f0);
            settle;
            `CHK("clamp high", 8'hc0, dac_code_out[15:8])
            wr(8'h64, 32'h0000_0055);
            settle;
            `CHK("code passes", 8'h55, dac_code_out[15:8])
            wr(8'h74, 32'h0101_30c0);
            settle;
            `CHK("hi-z", 2'b00, {dac_drive_out[1], dac_track_out[1]})
        end
    endtask
    // verdict and stop
    task end_of_test;
        begin
            if (err_total == 0 && comparisons > 0)
                $display("Run complete: PASS");
            else
                $display("Run complete: FAIL");
            $finish;
        end
    endtask
    // watchdog: over ten times the expected run
    initial begin
        #200000;
        err_total = err_total + 1;
        end_of_test;
    end
    // main sequence
    initial begin
        reset_n = 1'b0;
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0000_0000;
        sequencing_engine_start = 1'b0;
        repeat (8) @(posedge core_clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        t_reset;
        t_single;
        t_warn;
        t_avg;
        t_cont;
        t_dac;
        end_of_test;
    end
endmodule // test_adc_round_robin_and_margin_dac_control
